// ===== hw/lane_cond_consts.svh
// Purpose: Offsets, field positions, reset values of the lane conditioning registers
// Assumes: Byte-wide registers on an 8-bit register address
// Notes:   Definitions only
`ifndef LANE_COND_CONSTS_SVH
`define LANE_COND_CONSTS_SVH

// Register offsets
`define OFS_IN0_EQ        8'h2C
`define OFS_OUTA0_SWING   8'h2D
`define OFS_OUTA0_DEEMPH  8'h2E
`define OFS_IN0_IDLE_THR  8'h2F
`define OFS_OUTB0_IDLERT  8'h32
`define OFS_OUTB0_SWING   8'h34

// Reset values
`define RST_IN0_EQ        8'h20
`define RST_SWING         8'h03
`define RST_DEEMPH        8'h03
`define RST_IDLE_THR      8'h00
`define RST_IDLERT        8'h00

// Field positions
`define EQ_EN_BIT         5
`define EQ_GAIN_HI        4
`define EQ_GAIN_LO        3
`define EQ_BOOST_HI       2
`define DEEMPH_TYPE_BIT   7
`define THR_DEASSERT_HI   3
`define THR_DEASSERT_LO   2
`define THR_ASSERT_HI     1
`define IDLE_AUTO_BIT     5
`define IDLE_SEL_BIT      4
`define RATE_AUTO_BIT     1
`define RATE_SEL_BIT      0

// Swing codes
`define SWING_600MV       7'h03
`define SWING_800MV       7'h07
`define SWING_1000MV      7'h0F
`define SWING_1200MV      7'h1F
`define SWING_RESERVED    7'h3F

`endif

// ===== hw/lane_cond_pkg.sv
// Purpose: Types carried between the register bank and the analog controls
// Assumes: Constants come from lane_cond_consts.svh
// Notes:   Types only
`default_nettype none
package lane_cond_pkg;

  typedef struct packed {
    logic       enable;
    logic [1:0] gainStage;
    logic [2:0] boostLevel;
    logic [9:0] boostTenthDb;   // 0 when the code is not a listed setting
  } eq_cfg_s;

  typedef struct packed {
    logic       enhanced;
    logic [6:0] level;
    logic [7:0] deemphTenthDb;  // Magnitude of the negative figure
    logic [6:0] swingCode;
    logic [10:0] swingMv;        // 0 for unlisted codes
    logic       swingReserved;
  } drive_cfg_s;

  typedef struct packed {
    logic [7:0] deassertMv;
    logic [7:0] assertMv;
    logic       sigDetectEn;
    logic       outMute;
    logic       rateHigh;       // 1: 5.0 to 6.4 Gbps, 0: 2.5 to 3.2 Gbps
  } idle_cfg_s;

endpackage : lane_cond_pkg
`default_nettype wire

// ===== hw/cond_reg_cell.sv
// Purpose: One byte-wide read/write configuration register
// Assumes: Write strobe comes from logic on clk
// Notes:   Reserved bits are stored like any other
`default_nettype none
module cond_reg_cell #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output logic [7:0]      value_ff
);
  // Async reset to the register's own default
  always_ff @(posedge clk or posedge rst) begin
    if (rst) value_ff <= RESET_VAL;
    else if (wrEn) value_ff <= wrData;
  end
endmodule // cond_reg_cell
`default_nettype wire

// ===== hw/lane_conditioning_config_regs.sv
// Purpose: Configuration register bank for one conditioning lane
// Assumes: Register port is the management bus engine on clk; detector inputs asynchronous
// Notes:   Read data is registered, one cycle after the read strobe
// Function
// - Equalizer byte: bit5 enable, bits4:3 gain stage, bits2:0 boost level.
// - Equalizer resets to 20h, bypass, no boost until reprogrammed.
// - Listed equalizer codes map to their boost figures at 3 GHz.
// - Swing codes 03/07/0F/1F give 600-1200 mV; 3F reserved.
// - De-emphasis bit7 picks type; bits6:0 hold the level.
// - De-emphasis codes 01/E8/88/90/A0 give 0 to -12 dB; reset 03h.
// - Idle threshold bits3:2 set de-assert level, bits1:0 assert level.
// - Idle-auto bit5 set: automatic idle; clear: manual bit4 rules.
// - Manual idle-select 0 keeps output on, detect off; 1 mutes.
// - Rate-auto bit1 set: automatic rate; clear: manual bit0 rules.
// - Manual rate-select 0 is 2.5-3.2 Gbps, 1 is 5.0-6.4 Gbps.
`include "lane_cond_consts.svh"
`default_nettype none
module lane_conditioning_config_regs (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      regWrEn,
  input  wire logic                      regRdEn,
  input  wire logic [7:0]                regAddr,
  input  wire logic [7:0]                regWrData,
  output logic [7:0]                     regRdData,
  output logic                           regAddrHit,
  input  wire logic                      idleDetAsync,
  input  wire logic                      rateDetAsync,
  output lane_cond_pkg::eq_cfg_s         eqCfg,
  output lane_cond_pkg::drive_cfg_s      outACfg,
  output lane_cond_pkg::drive_cfg_s      outBCfg,
  output lane_cond_pkg::idle_cfg_s       idleCfg
);
  localparam int NREG = 6;
  localparam logic [NREG*8-1:0] OFS_LIST = {`OFS_OUTB0_SWING, `OFS_OUTB0_IDLERT,
    `OFS_IN0_IDLE_THR, `OFS_OUTA0_DEEMPH, `OFS_OUTA0_SWING, `OFS_IN0_EQ};
  localparam logic [NREG*8-1:0] RST_LIST = {`RST_SWING, `RST_IDLERT,
    `RST_IDLE_THR, `RST_DEEMPH, `RST_SWING, `RST_IN0_EQ};

  // Boost in tenths of dB for the listed codes
  function automatic logic [9:0] eqBoost(input logic [5:0] c);
    case (c)
      6'h2A:   eqBoost = 10'h032;
      6'h30:   eqBoost = 10'h05A;
      6'h32:   eqBoost = 10'h075;
      6'h39:   eqBoost = 10'h092;
      6'h35:   eqBoost = 10'h0B8;
      6'h37:   eqBoost = 10'h0C8;
      6'h3B:   eqBoost = 10'h0D4;
      6'h3D:   eqBoost = 10'h11C;
      default: eqBoost = 10'h000;
    endcase
  endfunction

  // De-emphasis magnitude in tenths of dB
  function automatic logic [7:0] deemphDb(input logic [7:0] c);
    case (c)
      8'hE8:   deemphDb = 8'h23;
      8'h88:   deemphDb = 8'h3C;
      8'h90:   deemphDb = 8'h5A;
      8'hA0:   deemphDb = 8'h78;
      default: deemphDb = 8'h00;
    endcase
  endfunction

  // Swing in mV; used for both outputs
  function automatic logic [10:0] swingMv(input logic [6:0] c);
    case (c)
      `SWING_600MV:  swingMv = 11'h258;
      `SWING_800MV:  swingMv = 11'h320;
      `SWING_1000MV: swingMv = 11'h3E8;
      `SWING_1200MV: swingMv = 11'h4B0;
      default:       swingMv = 11'h000;
    endcase
  endfunction

  // Idle threshold pair lookups
  function automatic logic [7:0] deassertMv(input logic [1:0] c);
    case (c)
      2'h0:    deassertMv = 8'h6E;
      2'h1:    deassertMv = 8'h96;
      2'h2:    deassertMv = 8'hAA;
      default: deassertMv = 8'hBE;
    endcase
  endfunction

  function automatic logic [7:0] assertMv(input logic [1:0] c);
    case (c)
      2'h0:    assertMv = 8'h46;
      2'h1:    assertMv = 8'h6E;
      2'h2:    assertMv = 8'h82;
      default: assertMv = 8'h96;
    endcase
  endfunction

  function automatic lane_cond_pkg::drive_cfg_s driveDecode(input logic [7:0] sw,
                                                             input logic [7:0] de);
    lane_cond_pkg::drive_cfg_s d;
    d.enhanced      = de[`DEEMPH_TYPE_BIT];
    d.level         = de[6:0];
    d.deemphTenthDb = deemphDb(de);
    d.swingCode     = sw[6:0];
    d.swingMv       = swingMv(sw[6:0]);
    d.swingReserved = (sw[6:0] == `SWING_RESERVED);
    driveDecode     = d;
  endfunction

  // Address decode, one hit line per register
  logic [NREG-1:0] hit;
  logic [7:0]      regVal [NREG];
  logic [7:0]      rdMux;

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = (regAddr == OFS_LIST[gi*8 +: 8]);
      cond_reg_cell #(.RESET_VAL(RST_LIST[gi*8 +: 8])) u_cell (
        .clk      (clk),
        .rst      (rst),
        .wrEn     (regWrEn & hit[gi]),
        .wrData   (regWrData),
        .value_ff (regVal[gi])
      );
    end
  endgenerate

  // Unmapped addresses read zero; writes to them are dropped
  always_comb begin
    rdMux = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) rdMux = regVal[i];
    end
  end
  assign regAddrHit = |hit;

  logic [7:0] rdData_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rdData_ff <= 8'h00;
    else if (regRdEn) rdData_ff <= rdMux;
  end
  assign regRdData = rdData_ff;

  // Two-stage synchronisers for the analog detector levels
  logic [1:0] idleSync_ff;
  logic [1:0] rateSync_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idleSync_ff <= 2'b00;
      rateSync_ff <= 2'b00;
    end else begin
      idleSync_ff <= {idleSync_ff[0], idleDetAsync};
      rateSync_ff <= {rateSync_ff[0], rateDetAsync};
    end
  end

  // Field views
  wire [7:0] eqReg   = regVal[0];
  wire [7:0] thrReg  = regVal[3];
  wire [7:0] modeReg = regVal[4];
  wire       idleAuto = modeReg[`IDLE_AUTO_BIT];
  wire       rateAuto = modeReg[`RATE_AUTO_BIT];

  // Equalizer decode; bypass from reset since enable-only code has no boost
  assign eqCfg.enable       = eqReg[`EQ_EN_BIT];
  assign eqCfg.gainStage    = eqReg[`EQ_GAIN_HI:`EQ_GAIN_LO];
  assign eqCfg.boostLevel   = eqReg[`EQ_BOOST_HI:0];
  assign eqCfg.boostTenthDb = eqBoost(eqReg[5:0]);

  // Output drive decode, shared function for both outputs
  assign outACfg = driveDecode(regVal[1], regVal[2]);
  assign outBCfg = driveDecode(regVal[5], 8'h00);

  // Idle thresholds; reserved upper bits ignored
  assign idleCfg.deassertMv = deassertMv(thrReg[`THR_DEASSERT_HI:`THR_DEASSERT_LO]);
  assign idleCfg.assertMv   = assertMv(thrReg[`THR_ASSERT_HI:0]);

  // Auto mode overrides the manual bit for both mute and rate
  assign idleCfg.sigDetectEn = idleAuto | modeReg[`IDLE_SEL_BIT];
  assign idleCfg.outMute  = idleAuto ? idleSync_ff[1] : modeReg[`IDLE_SEL_BIT];
  assign idleCfg.rateHigh = rateAuto ? rateSync_ff[1] : modeReg[`RATE_SEL_BIT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  eq_reset_a: assert property ($fell(rst) |->
      eqCfg.boostTenthDb == 10'h000 && eqCfg.enable)
    else $error("equalizer not bypass after reset");
  eq_fields_a: assert property (regWrEn && regAddr == `OFS_IN0_EQ |=>
      {eqCfg.enable, eqCfg.gainStage, eqCfg.boostLevel} == $past(regWrData[5:0]))
    else $error("equalizer fields mismatch write");
  eq_max_a: assert property (regWrEn && regAddr == `OFS_IN0_EQ && regWrData == 8'h3D
      |=> eqCfg.boostTenthDb == 10'h11C)
    else $error("top boost code wrong");
  swing_map_a: assert property (regWrEn && regAddr == `OFS_OUTA0_SWING
      && regWrData == 8'h1F |=> outACfg.swingMv == 11'h4B0 && !outACfg.swingReserved)
    else $error("1200 mV code wrong");
  deemph_type_a: assert property (regWrEn && regAddr == `OFS_OUTA0_DEEMPH |=>
      outACfg.enhanced == $past(regWrData[7]) && outACfg.level == $past(regWrData[6:0]))
    else $error("de-emphasis fields wrong");
  deemph_max_a: assert property (regWrEn && regAddr == `OFS_OUTA0_DEEMPH
      && regWrData == 8'hA0 |=> outACfg.deemphTenthDb == 8'h78)
    else $error("-12 dB code wrong");
  thr_pair_a: assert property (regWrEn && regAddr == `OFS_IN0_IDLE_THR
      && regWrData == 8'h06 |=> idleCfg.deassertMv == 8'h96 && idleCfg.assertMv == 8'h82)
    else $error("threshold pair wrong");
  manual_mute_a: assert property (!idleAuto |-> idleCfg.outMute == modeReg[4]
      && idleCfg.sigDetectEn == modeReg[4])
    else $error("manual mute wrong");
  // Detector level reaches the mute output through exactly two flops
  auto_mute_a: assert property (idleAuto && $stable(idleAuto) |->
      idleCfg.outMute == $past(idleDetAsync, 2))
    else $error("auto mute not from detector");
  rate_sel_a: assert property (!rateAuto |-> idleCfg.rateHigh == modeReg[0])
    else $error("manual rate wrong");
  // Write, one idle edge, then read of the same register
  readback_a: assert property (regWrEn && regAddr == `OFS_OUTB0_IDLERT ##1 !regWrEn
      ##1 regRdEn && !regWrEn && regAddr == `OFS_OUTB0_IDLERT
      |=> regRdData == $past(regWrData, 3))
    else $error("readback lost reserved bits");

  eq_boost_c: cover property (regWrEn && regAddr == `OFS_IN0_EQ ##1 eqCfg.boostTenthDb != 0);
  auto_idle_c: cover property (idleAuto && idleCfg.outMute);
  rate_high_c: cover property (!rateAuto && idleCfg.rateHigh);
  unmapped_c: cover property (regRdEn && !regAddrHit);

endmodule // lane_conditioning_config_regs
`default_nettype wire

// ===== tb/mgmt_host_model.sv
// Purpose: Management host model driving the register strobe port
// Assumes: Requests start 1 ns after a rising edge
// Notes:   Released address and data lines show the inverse value
`default_nettype none
module mgmt_host_model (
  input  wire logic       clk,
  output logic            regWrEn,
  output logic            regRdEn,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData,
  input  wire logic       regAddrHit
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
  end
  // Write: one taken edge, then one idle edge so strobes never toggle twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    regAddr = ~a;  // Stale values must not look valid
    regWrData = ~d;
    @(posedge clk);
    #1;
  endtask
  // Read: decode hit sampled at the taken edge, data after it settles
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    h = regAddrHit;
    #1;
    regRdEn = 1'b0;
    regAddr = ~a;
    d = regRdData;
    @(posedge clk);
    #1;
  endtask
endmodule // mgmt_host_model
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the lane conditioning register bank
// Assumes: Host model drives the strobe port; bench drives detectors
// Notes:   Expected figures come from the decode tables below
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, regWrEn, regRdEn, idleDetAsync, rateDetAsync, regAddrHit, hit;
  logic [7:0] regAddr, regWrData, regRdData, rdv;
  lane_cond_pkg::eq_cfg_s    eqCfg;
  lane_cond_pkg::drive_cfg_s outACfg, outBCfg;
  lane_cond_pkg::idle_cfg_s  idleCfg;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam logic [7:0] OFS [6] = '{8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h32, 8'h34};
  localparam logic [7:0] RSTV [6] = '{8'h20, 8'h03, 8'h03, 8'h00, 8'h00, 8'h03};
  localparam logic [7:0] EQC [8] = '{8'h2A, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3B, 8'h3D};
  localparam logic [9:0] EQD [8] = '{10'h32, 10'h5A, 10'h75, 10'h92, 10'hB8, 10'hC8, 10'hD4,
                                     10'h11C};
  localparam logic [6:0] SWC [5] = '{7'h03, 7'h07, 7'h0F, 7'h1F, 7'h3F};
  localparam logic [10:0] SWM [5] = '{11'h258, 11'h320, 11'h3E8, 11'h4B0, 11'h000};
  localparam logic [7:0] DEC [5] = '{8'h01, 8'hE8, 8'h88, 8'h90, 8'hA0};
  localparam logic [7:0] DED [5] = '{8'h00, 8'h23, 8'h3C, 8'h5A, 8'h78};
  localparam logic [7:0] THD [4] = '{8'h6E, 8'h96, 8'hAA, 8'hBE};
  localparam logic [7:0] THA [4] = '{8'h46, 8'h6E, 8'h82, 8'h96};
  initial clk = 1'b0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  lane_conditioning_config_regs dut (.clk(clk), .rst(rst), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .regAddrHit(regAddrHit), .idleDetAsync(idleDetAsync), .rateDetAsync(rateDetAsync),
    .eqCfg(eqCfg), .outACfg(outACfg), .outBCfg(outBCfg), .idleCfg(idleCfg));
  mgmt_host_model host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regAddrHit(regAddrHit));
  // Compare and count; four-state equality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    idleDetAsync = 1'b0;
    rateDetAsync = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    foreach (OFS[i]) begin
      host.rd(OFS[i], rdv, hit);
      check({hit, rdv}, {1'b1, RSTV[i]});
    end
    check({eqCfg.enable, eqCfg.boostTenthDb}, {1'b1, 10'h000});
    check({outACfg.swingMv, idleCfg.deassertMv, idleCfg.assertMv}, 32'h02586E46);
    check({idleCfg.sigDetectEn, idleCfg.outMute, idleCfg.rateHigh}, 3'b000);
    $display("test reset values done");
    foreach (EQC[i]) begin
      host.wr(8'h2C, EQC[i]);
      check({eqCfg.enable, eqCfg.gainStage, eqCfg.boostLevel}, EQC[i][5:0]);
      check(eqCfg.boostTenthDb, EQD[i]);
    end
    $display("test equalizer done");
    // Code 3F is written on purpose to see the reserved flag
    foreach (SWC[i]) begin
      host.wr(8'h2D, {1'b0, SWC[i]});
      host.wr(8'h34, {1'b0, SWC[i]});
      check({outACfg.swingMv, outACfg.swingReserved}, {SWM[i], i == 4});
      check({outBCfg.swingCode, outBCfg.swingMv}, {SWC[i], SWM[i]});
    end
    foreach (DEC[i]) begin
      host.wr(8'h2E, DEC[i]);
      check({outACfg.enhanced, outACfg.level}, DEC[i]);
      check(outACfg.deemphTenthDb, DED[i]);
    end
    $display("test drive settings done");
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h2F, {4'h0, i[1:0], ~i[1:0]});
      check({idleCfg.deassertMv, idleCfg.assertMv}, {THD[i], THA[3-i]});
    end
    host.wr(8'h32, 8'h10);
    check({idleCfg.outMute, idleCfg.rateHigh}, 2'b10);
    host.wr(8'h32, 8'h01);
    check({idleCfg.sigDetectEn, idleCfg.outMute, idleCfg.rateHigh}, 3'b001);
    // Auto modes with manual bits set: only detector levels may count
    host.wr(8'h32, 8'h33);
    check({idleCfg.sigDetectEn, idleCfg.outMute, idleCfg.rateHigh}, 3'b100);
    idleDetAsync = 1'b1;
    rateDetAsync = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({idleCfg.outMute, idleCfg.rateHigh}, 2'b11);
    host.wr(8'h32, 8'h00);
    check({idleCfg.outMute, idleCfg.rateHigh}, 2'b00);
    $display("test idle and rate done");
    // Reserved bits set deliberately; zero is what software should write
    host.wr(8'h2C, 8'hC0);
    host.rd(8'h2C, rdv, hit);
    check({rdv, eqCfg.enable, eqCfg.boostTenthDb}, {8'hC0, 11'h000});
    host.wr(8'h30, 8'h5A);
    host.rd(8'h30, rdv, hit);
    check({hit, rdv}, 9'h000);
    // Reserved bits only: stored and read back, modes stay manual and clear
    host.wr(8'h32, 8'hCC);
    host.rd(8'h32, rdv, hit);
    check({hit, rdv}, {1'b1, 8'hCC});
    check({idleCfg.sigDetectEn, idleCfg.outMute, idleCfg.rateHigh}, 3'b000);
    // Second reset in mid-run restores the bypass setting
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    host.rd(8'h2C, rdv, hit);
    check(rdv, 8'h20);
    $display("test reserved and unmapped done");
    end_of_test();
  end
  // Watchdog: the sequence needs well under 20 us
  initial begin
    #50us;
    n_mismatch++;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
